// File: spi_port_pkg.sv
// shared constants for the serial port of the reader front end
package spi_port_pkg;
	localparam int byte_bits = 8;
	localparam int addr_bits = 6;
	localparam logic [1:0] mode_reg_write = 2'h0;
	localparam logic [1:0] mode_reg_read = 2'h1;
	localparam logic [1:0] mode_fifo = 2'h2;
	localparam logic [1:0] mode_direct_cmd = 2'h3;
	localparam logic [5:0] fifo_load_code = 6'h00;
	localparam logic [5:0] fifo_read_code = 6'h3f;
	localparam int fifo_max_bytes = 96;
	localparam logic [2:0] last_bit_index = 3'h7;
	localparam logic [6:0] reg_count = 7'h40;
	localparam logic [5:0] read_only_base = 6'h30;
	localparam logic [5:0] unmapped_base = 6'h38;
	localparam logic [7:0] reg_reset_value = 8'h00;
	localparam logic [3:0] sclk_half_div = 4'h4;
	// low-phase count at which the host takes the returned bit
	localparam logic [3:0] sample_div = 4'h2;
endpackage : spi_port_pkg

// File: spi_link_if.sv
// serial link between the microcontroller and the reader port
`timescale 1ns/1ns
interface spi_link_if;
	logic select_n;
	logic sclk;
	logic mosi;
	logic miso_out;
	logic miso_oe;
	logic pulldown_on;
	logic miso;
	// a driven pin wins; otherwise the weak pull-down, else the opposite of the last bit
	assign miso = miso_oe ? miso_out : (pulldown_on ? 1'b0 : ~miso_out);
	modport device (input select_n, input sclk, input mosi,
		output miso_out, output miso_oe, output pulldown_on);
	modport host (output select_n, output sclk, output mosi, input miso);
endinterface : spi_link_if

// File: spi_device_port.sv
// reader-side serial slave port: mode decode, registers, fifo gates, commands
`timescale 1ns/1ns
module spi_device_port
	import spi_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	spi_link_if.device link,
	input wire logic main_enable,
	input wire logic osc_stable,
	input wire logic serial_out_pulldown_a,
	input wire logic serial_out_pulldown_b,
	input wire logic [7:0] rx_fifo_data,
	input wire logic rx_fifo_empty,
	output logic rx_fifo_pop,
	output logic tx_fifo_push,
	output logic [7:0] tx_fifo_data,
	output logic cmd_valid,
	output logic [5:0] cmd_code,
	output logic cmd_busy_block
);
	typedef enum logic [5:0] {
		st_mode = 6'h01,
		st_wdata = 6'h02,
		st_rdata = 6'h04,
		st_load = 6'h08,
		st_fread = 6'h10,
		st_idle = 6'h20
	} state_t;

	typedef struct packed {
		logic [1:0] ss_sync;
		logic [1:0] clk_sync;
		logic [1:0] mosi_sync;
		logic clk_prev;
		state_t state;
		logic [2:0] bit_cnt;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic [5:0] addr;
		logic out_active;
		logic miso_out;
		logic miso_oe;
		logic pulldown_on;
		logic rx_fifo_pop;
		logic tx_fifo_push;
		logic [7:0] tx_fifo_data;
		logic cmd_valid;
		logic [5:0] cmd_code;
		logic [(unmapped_base * 8) - 1:0] regs;
	} port_state_t;

	port_state_t cur;
	port_state_t nxt;

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	function automatic logic [7:0] reg_value(input logic [5:0] a, input port_state_t s);
		logic [7:0] v;
		v = 8'h00;
		if (a < unmapped_base) begin
			v = s.regs[a * 8 +: 8];
		end
		return v;
	endfunction : reg_value

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] full_byte;
		logic fall;
		logic rise;
		logic sel;
		nxt = cur;
		full_byte = 8'h00;
		nxt.ss_sync = {cur.ss_sync[0], link.select_n};
		nxt.clk_sync = {cur.clk_sync[0], link.sclk};
		nxt.mosi_sync = {cur.mosi_sync[0], link.mosi};
		nxt.clk_prev = cur.clk_sync[1];
		fall = cur.clk_prev & ~cur.clk_sync[1];
		rise = ~cur.clk_prev & cur.clk_sync[1];
		sel = ~cur.ss_sync[1];
		nxt.rx_fifo_pop = 1'b0;
		nxt.tx_fifo_push = 1'b0;
		nxt.cmd_valid = 1'b0;
		if (!sel) begin
			// deselected: abandon any partial byte, float the output
			nxt.state = st_mode;
			nxt.bit_cnt = 3'h0;
			nxt.out_active = 1'b0;
			nxt.miso_oe = 1'b0;
		end else begin
			if (fall) begin
				full_byte = {cur.shift_in[6:0], cur.mosi_sync[1]};
				nxt.shift_in = full_byte;
				nxt.bit_cnt = cur.bit_cnt + 3'h1;
				if (cur.bit_cnt == last_bit_index) begin
					case (cur.state)
						st_mode: begin
							nxt.addr = full_byte[5:0];
							case (full_byte[7:6])
								mode_reg_write: nxt.state = st_wdata;
								mode_reg_read: begin
									nxt.state = st_rdata;
									nxt.shift_out = reg_value(full_byte[5:0], cur);
									nxt.out_active = 1'b1;
								end
								mode_fifo: begin
									if (!(main_enable && osc_stable)) begin
										nxt.state = st_idle;
									end else if (full_byte[5:0] == fifo_load_code) begin
										nxt.state = st_load;
									end else if (full_byte[5:0] == fifo_read_code) begin
										nxt.state = st_fread;
										nxt.shift_out = rx_fifo_data;
										nxt.out_active = ~rx_fifo_empty;
									end else begin
										nxt.state = st_idle;
									end
								end
								default: begin
									nxt.cmd_valid = 1'b1;
									nxt.cmd_code = full_byte[5:0];
									nxt.state = st_mode;
								end
							endcase
						end
						st_wdata: begin
							if (cur.addr < read_only_base) begin
								nxt.regs[cur.addr * 8 +: 8] = full_byte;
							end
							nxt.addr = cur.addr + 6'h1;
						end
						st_rdata: begin
							nxt.addr = cur.addr + 6'h1;
							nxt.shift_out = reg_value(cur.addr + 6'h1, cur);
						end
						st_load: begin
							nxt.tx_fifo_push = 1'b1;
							nxt.tx_fifo_data = full_byte;
						end
						st_fread: begin
							// byte fully shifted: only now consume it
							nxt.rx_fifo_pop = cur.out_active;
							nxt.out_active = 1'b0;
						end
						default: nxt.state = st_idle;
					endcase
				end
			end
			if (cur.state == st_fread && !cur.out_active && !cur.rx_fifo_pop
				&& !rx_fifo_empty && cur.bit_cnt == 3'h0) begin
				nxt.shift_out = rx_fifo_data;
				nxt.out_active = 1'b1;
			end
			if (rise && cur.out_active) begin
				nxt.miso_out = cur.shift_out[last_bit_index - cur.bit_cnt];
				nxt.miso_oe = 1'b1;
			end
			if (rise && !cur.out_active) begin
				nxt.miso_oe = 1'b0;
			end
		end
		nxt.pulldown_on = serial_out_pulldown_a & serial_out_pulldown_b & ~nxt.miso_oe;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cur <= '0;
			cur.state <= st_mode;
			cur.ss_sync <= 2'h3;
			cur.regs <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign link.miso_out = cur.miso_out;
	assign link.miso_oe = cur.miso_oe;
	assign link.pulldown_on = cur.pulldown_on;
	assign rx_fifo_pop = cur.rx_fifo_pop;
	assign tx_fifo_push = cur.tx_fifo_push;
	assign tx_fifo_data = cur.tx_fifo_data;
	assign cmd_valid = cur.cmd_valid;
	assign cmd_code = cur.cmd_code;
	// long commands run outside this port; the master keeps the link idle meanwhile
	assign cmd_busy_block = 1'b0;
endmodule : spi_device_port

// File: spi_host_port.sv
// microcontroller-side serial master: sends one byte per order, returns read byte
`timescale 1ns/1ns
module spi_host_port
	import spi_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	spi_link_if.host link,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	// addr 0: tx byte (write starts transfer); addr 1: control bit0 = select
	// addr 2 read: bit0 busy; addr 3 read: last received byte
	typedef enum logic [1:0] {
		hs_idle = 2'h1,
		hs_run = 2'h2
	} hstate_t;

	typedef struct packed {
		hstate_t state;
		logic select_n;
		logic sclk;
		logic mosi;
		logic [3:0] div;
		logic [3:0] bits;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [1:0] miso_sync;
		logic [7:0] rdata;
	} host_state_t;

	host_state_t cur;
	host_state_t nxt;

	always_comb begin
		nxt = cur;
		nxt.miso_sync = {cur.miso_sync[0], link.miso};
		if (wr && addr == 2'h1) begin
			nxt.select_n = ~wdata[0];
		end
		case (cur.state)
			hs_idle: begin
				if (wr && addr == 2'h0) begin
					nxt.state = hs_run;
					nxt.tx = {wdata[6:0], 1'b0};
					nxt.mosi = wdata[7];
					nxt.bits = 4'h0;
					nxt.div = 4'h0;
				end
			end
			hs_run: begin
				nxt.div = cur.div + 4'h1;
				if (!cur.sclk && cur.div == sample_div && cur.bits != 4'h0) begin
					// the reply crosses both ends' synchronisers, so it is taken
					// inside the low phase that follows the fall
					nxt.rx = {cur.rx[6:0], cur.miso_sync[1]};
					if (cur.bits == 4'h8) begin
						nxt.state = hs_idle;
					end
				end
				if (cur.div == sclk_half_div - 4'h1 && cur.bits != 4'h8) begin
					nxt.div = 4'h0;
					nxt.sclk = ~cur.sclk;
					if (cur.sclk) begin
						nxt.bits = cur.bits + 4'h1;
					end else if (cur.bits != 4'h0) begin
						// next bit leaves on the rise, so it is steady at the fall
						nxt.mosi = cur.tx[7];
						nxt.tx = {cur.tx[6:0], 1'b0};
					end
				end
			end
			default: nxt.state = hs_idle;
		endcase
		if (wr && addr == 2'h1 && !wdata[0]) begin
			// deselect cuts a byte short: park the clock low and stop
			nxt.state = hs_idle;
			nxt.sclk = 1'b0;
		end
		nxt.rdata = 8'h00;
		if (rd) begin
			case (addr)
				2'h1: nxt.rdata = {7'h00, ~cur.select_n};
				2'h2: nxt.rdata = {7'h00, cur.state == hs_run};
				2'h3: nxt.rdata = cur.rx;
				default: nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cur <= '0;
			cur.state <= hs_idle;
			cur.select_n <= 1'b1;
		end else begin
			cur <= nxt;
		end
	end

	assign link.select_n = cur.select_n;
	assign link.sclk = cur.sclk;
	assign link.mosi = cur.mosi;
	assign rdata = cur.rdata;
endmodule : spi_host_port

// File: spi_link_props.sv
// assertions on the serial link between host port and reader port
`timescale 1ns/1ns
module spi_link_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic select_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso_out,
	input wire logic miso_oe,
	input wire logic pulldown_on
);
	logic sclk_d;
	logic [2:0] rises;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// counts clock rises while selected
	always_ff @(posedge ref_clk) begin
		sclk_d <= sclk;
		if (sys_rst || select_n) begin
			rises <= 3'h0;
		end else begin
			rises <= rises + {2'h0, sclk & ~sclk_d};
		end
	end
	a_desel_quiet: assert property (select_n [*6] |-> !miso_oe)
		else $error("output driven while deselected");
	a_idle_clock: assert property (select_n |-> !sclk)
		else $error("clock high while deselected");
	a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("data in moved while clock high");
	a_clock_high_len: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("clock high phase length wrong");
	a_cut_byte_quiet: assert property ($rose(select_n) && rises != 3'h0 |-> ##4 !miso_oe)
		else $error("output still driven after a cut byte");
	a_drive_no_pull: assert property (miso_oe |-> !pulldown_on)
		else $error("pull-down on while driving");
	a_launch_rise: assert property (miso_oe && $changed(miso_out) |-> $past(sclk, 2))
		else $error("output bit not launched after rise");
	a_oe_needs_sel: assert property (miso_oe |-> !$past(select_n, 5))
		else $error("output driven after deselect");
endmodule : spi_link_props

// File: nfc_reader_spi_slave_port_tb.sv
// bench: host port drives the reader port over the link, results taken from queues
`timescale 1ns/1ns
module nfc_reader_spi_slave_port_tb
	import spi_port_pkg::*;
;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic main_enable = 1'b1;
	logic osc_stable = 1'b1;
	logic serial_out_pulldown_a = 1'b1;
	logic serial_out_pulldown_b = 1'b1;
	logic [7:0] rx_fifo_data = 8'h00;
	logic rx_fifo_empty = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic look = 1'b0;
	logic rx_fifo_pop, tx_fifo_push, cmd_valid;
	logic [5:0] cmd_code, c;
	logic [7:0] tx_fifo_data, rdata, v, w0, w1;
	logic [1:0] npop = 2'h0;
	logic [7:0] rx_tab [4];
	logic [8:0] oq [$];
	logic [7:0] rq [$];
	int bad_count = 0;
	int num_checks = 0;
	int seed = 32'h9f92;
	int cyc = 0;
	always #20 ref_clk = ~ref_clk;
	spi_link_if link ();
	spi_device_port spi_device_port_i (.ref_clk, .sys_rst, .link, .main_enable, .osc_stable,
		.serial_out_pulldown_a, .serial_out_pulldown_b, .rx_fifo_data, .rx_fifo_empty,
		.rx_fifo_pop, .tx_fifo_push, .tx_fifo_data, .cmd_valid, .cmd_code, .cmd_busy_block());
	spi_host_port spi_host_port_i (.ref_clk, .sys_rst, .link, .addr, .wdata, .wr, .rd, .rdata);
	spi_link_props spi_link_props_i (.ref_clk, .sys_rst, .select_n(link.select_n),
		.sclk(link.sclk), .mosi(link.mosi), .miso_out(link.miso_out), .miso_oe(link.miso_oe),
		.pulldown_on(link.pulldown_on));
	task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	function automatic logic [8:0] note();
		return oq.size() > 0 ? oq.pop_front() : 9'h1ff;
	endfunction : note
	// receive fifo head advances on each pop; also the hang limit
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (rx_fifo_pop) begin
			npop <= npop + 2'h1;
			rx_fifo_data <= rx_tab[npop + 2'h1];
		end
		if (cyc == 30000) begin
			bad_count++;
			finish_test();
		end
	end
	always @(negedge ref_clk) begin
		if (look) begin
			look = 1'b0;
			check("rdata", {1'b0, rdata}, {1'b0, rq.pop_front()});
		end
		if (tx_fifo_push) check("push", {1'b0, tx_fifo_data}, note());
		if (cmd_valid) check("cmd", {3'h4, cmd_code}, note());
	end
	task op(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask : op
	task get(input logic [1:0] a);
		op(1'b0, 1'b1, a, 8'h00);
		op(1'b0, 1'b0, a, 8'h00);
		#1 v = rdata;
	endtask : get
	// one byte each way; k asks for the received byte to be compared with e
	task xb(input logic [7:0] b, input logic k, input logic [7:0] e);
		int n;
		op(1'b1, 1'b0, 2'h0, b);
		v = 8'h01;
		for (n = 0; n < 99 && v[0]; n++) get(2'h2);
		if (v[0]) bad_count++;
		if (k) rq.push_back(e);
		op(1'b0, k, 2'h3, 8'h00);
		op(1'b0, 1'b0, 2'h3, 8'h00);
		look = k;
	endtask : xb
	task sel(input logic s);
		repeat (12) @(posedge ref_clk);
		op(1'b1, 1'b0, 2'h1, {7'h00, s});
		op(1'b0, 1'b0, 2'h1, 8'h00);
	endtask : sel
	// starts a byte and deselects after its first bit, in the clock's low phase
	task cut(input logic [7:0] b);
		op(1'b1, 1'b0, 2'h0, b);
		op(1'b0, 1'b0, 2'h0, 8'h00);
		repeat (9) @(posedge ref_clk);
		op(1'b1, 1'b0, 2'h1, 8'h00);
		op(1'b0, 1'b0, 2'h1, 8'h00);
	endtask : cut
	initial begin
		for (int i = 0; i < 4; i++) rx_tab[i] = 8'($random(seed));
		rx_fifo_data = rx_tab[0];
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			c = i == 0 ? 6'h37 : (i == 1 ? 6'h2f : 6'h05);
			w0 = 8'($random(seed));
			w1 = 8'($random(seed));
			sel(1'b1);
			xb({mode_reg_write, c}, 1'b1, 8'h00);
			xb(w0, 1'b1, 8'h00);
			xb(w1, 1'b1, 8'h00);
			sel(1'b0);
			sel(1'b1);
			xb({mode_reg_read, c}, 1'b1, 8'h00);
			xb(8'h00, 1'b1, c < read_only_base ? w0 : 8'h00);
			xb(8'h00, 1'b1, c + 6'h01 < read_only_base ? w1 : 8'h00);
			sel(1'b0);
		end
		$display("test registers done");
		for (int i = 0; i < 2; i++) begin
			{main_enable, osc_stable} <= i == 0 ? 2'h3 : (seed[0] ? 2'h1 : 2'h2);
			serial_out_pulldown_b <= i == 0;
			sel(1'b1);
			check("pull", {8'h00, link.pulldown_on}, {8'h00, i == 0});
			xb({mode_fifo, fifo_load_code}, i == 0, 8'h00);
			repeat (2) begin
				w0 = 8'($random(seed));
				if (i == 0) oq.push_back({1'b0, w0});
				xb(w0, i == 0, 8'h00);
			end
			sel(1'b0);
		end
		$display("test fifo load done");
		{main_enable, osc_stable} <= 2'h3;
		serial_out_pulldown_b <= 1'b1;
		rx_fifo_empty <= 1'b0;
		sel(1'b1);
		xb({mode_fifo, fifo_read_code}, 1'b1, 8'h00);
		for (int i = 0; i < 3; i++) xb(8'h00, 1'b1, rx_tab[i]);
		sel(1'b0);
		rx_fifo_empty <= 1'b1;
		$display("test fifo read done");
		for (int i = 0; i < 4; i++) begin
			c = 6'($random(seed));
			oq.push_back({3'h4, c});
			sel(1'b1);
			xb({mode_direct_cmd, c}, 1'b1, 8'h00);
			xb({mode_reg_read, 6'h06}, 1'b1, 8'h00);
			xb(8'h00, 1'b1, w1);
			sel(1'b0);
		end
		$display("test command chain done");
		// each cut leaves one bit of a byte behind, which must come to nothing
		rx_fifo_empty <= 1'b0;
		sel(1'b1);
		xb({mode_reg_write, 6'h06}, 1'b1, 8'h00);
		cut(~w1);
		sel(1'b1);
		xb({mode_reg_read, 6'h06}, 1'b1, 8'h00);
		xb(8'h00, 1'b1, w1);
		sel(1'b0);
		sel(1'b1);
		xb({mode_fifo, fifo_load_code}, 1'b1, 8'h00);
		cut(8'h5a);
		sel(1'b1);
		xb({mode_fifo, fifo_read_code}, 1'b1, 8'h00);
		cut(8'h00);
		sel(1'b1);
		xb({mode_fifo, fifo_read_code}, 1'b1, 8'h00);
		xb(8'h00, 1'b1, rx_tab[3]);
		sel(1'b0);
		rx_fifo_empty <= 1'b1;
		$display("test cut bytes done");
		repeat (20) @(posedge ref_clk);
		check("notes left", 9'(oq.size()), 9'h000);
		finish_test();
	end
endmodule : nfc_reader_spi_slave_port_tb
